//--- verilog/mali_pkg.sv
package mali_pkg;
    localparam int         AXES     = 4;
    localparam logic [6:0] OP_CLIN1 = 7'h60;
    localparam logic [6:0] OP_LIN1  = 7'h61;
    localparam logic [6:0] OP_CLIN2 = 7'h62;
    localparam logic [6:0] OP_LIN2  = 7'h63;
    localparam logic [6:0] OP_CW    = 7'h64;
    localparam logic [6:0] OP_CCW   = 7'h65;
    localparam int         CSP_BIT  = 15;
    // byte address: [7] global, [6:5] axis, [4:2] register
    localparam int         ADR_GLB  = 7;
    localparam int         ADR_AXL  = 5;
    localparam int         ADR_RGL  = 2;
    localparam logic [2:0] RG_MODE  = 3'h0;
    localparam logic [2:0] RG_TGT   = 3'h1;
    localparam logic [2:0] RG_AUX   = 3'h2;
    localparam logic [2:0] RG_HIGH  = 3'h3;
    localparam logic [2:0] RG_INIT  = 3'h4;
    localparam logic [2:0] RG_STAT  = 3'h5;
    localparam logic [2:0] RG_SPEED = 3'h6;
    localparam logic [7:0] ADDR_CMD = 8'h80;
    localparam int         CMD_OPL  = 4;
    localparam logic [1:0] CMD_GO_INIT = 2'h1;
    localparam logic [1:0] CMD_GO_HIGH = 2'h2;
    localparam logic [1:0] CMD_STOP    = 2'h3;
    localparam int         SB_RUN   = 0;
    localparam int         SB_END   = 1;
    localparam int         SB_ERR   = 2;
    localparam int         SB_CTL   = 3;
    localparam logic [31:0] MODE_RST  = 32'h0000_0000;
    localparam logic [31:0] AMT_RST   = 32'h0000_0000;
    localparam logic [31:0] SPEED_RST = 32'h0000_00FA;
    localparam logic [31:0] MIN_PER   = 32'h0000_0002;
    localparam int         Q_FRAC   = 7;
    localparam logic [7:0] Q_UNITY  = 8'h80;
    localparam logic [7:0] Q_SQRT2  = 8'hB5;
    localparam logic [7:0] Q_SQRT3  = 8'hDE;
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_RUN  = 2'b10
    } mali_state_e;
endpackage

//--- verilog/mali_step_if.sv
`timescale 1ns/100ps
interface mali_step_if;
    logic        load;
    logic        step;
    logic [31:0] master;
    logic [31:0] amt;
    logic        pulse;
    modport eng  (output load, step, master, amt, input pulse);
    modport axis (input load, step, master, amt, output pulse);
endinterface

//--- verilog/mali_axis.sv
`timescale 1ns/100ps
module mali_axis
    import mali_pkg::*;
(
    input wire logic  i_clk,
    input wire logic  i_srst,
    mali_step_if.axis sif
);
    logic [31:0] acc_r;
    logic [31:0] mst_r;
    logic [31:0] amt_r;
    logic        pulse_r;
    logic [32:0] sum_c;

    assign sum_c     = {1'b0, acc_r} + {1'b0, amt_r};
    assign sif.pulse = pulse_r;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            acc_r   <= AMT_RST;
            mst_r   <= AMT_RST;
            amt_r   <= AMT_RST;
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= 1'b0;
            if (sif.load) begin
                mst_r <= sif.master;
                amt_r <= sif.amt;
                // half-step preload keeps error within half a unit
                acc_r <= sif.master >> 1;
            end else if (sif.step) begin
                if (sum_c >= {1'b0, mst_r}) begin
                    acc_r   <= 32'(sum_c - {1'b0, mst_r});
                    pulse_r <= 1'b1;
                end else begin
                    acc_r <= sum_c[31:0];
                end
            end
        end
    end

    master_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)
        sif.step && !sif.load && amt_r == mst_r && mst_r != 32'h0
        |=> pulse_r)
        else $error("master axis missed a step");
    acc_bound_a: assert property (@(posedge i_clk) disable iff (i_srst)
        mst_r != 32'h0 && amt_r <= mst_r |-> acc_r < mst_r)
        else $error("accumulator left its range");
endmodule // mali_axis

//--- verilog/mali_interp.sv
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module mali_interp
    import mali_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_SRST,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [31:0] I_WB_DAT,
    input  wire logic [3:0]  I_WB_SEL,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    output logic      [3:0]  O_PULSE,
    output logic      [3:0]  O_DIR
);
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] mag(input logic [31:0] v);
        return v[31] ? 32'(-v) : v;
    endfunction

    function automatic logic [2:0] pop4(input logic [3:0] m);
        return 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
    endfunction

    // fixed X, Y, Z, U priority
    function automatic logic [1:0] first_axis(input logic [3:0] m);
        logic [1:0] r;
        r = 2'h0;
        for (int a = AXES - 1; a >= 0; a--) begin
            if (m[a]) begin
                r = 2'(a);
            end
        end
        return r;
    endfunction

    logic [31:0] mode_r [AXES];
    logic [31:0] tgt_r  [AXES];
    logic [31:0] aux_r  [AXES];
    logic [31:0] high_r [AXES];
    logic [31:0] init_r [AXES];
    logic        ack_r;
    logic [31:0] rdat_r;

    mali_state_e state_r;
    logic [3:0]  grp_r;
    logic [3:0]  csp_r;
    logic [3:0]  ctlm_r;
    logic [3:0]  dir_r;
    logic [3:0]  pls_r;
    logic        li2_r;
    logic        cont_r;
    logic        run_r;
    logic        end_r;
    logic        err_r;
    logic        wait_r;
    logic [31:0] master_r;
    logic [31:0] steps_r;
    logic [31:0] base_r;
    logic [31:0] per_r;
    logic [31:0] cnt_r;

    logic        req;
    logic        wr;
    logic [1:0]  ax_a;
    logic [2:0]  rg_a;
    logic        cmd_wr;
    logic [3:0]  sel_c;
    logic [1:0]  op_c;
    logic        go;
    logic        stop;
    logic [1:0]  ctl_c;
    logic [6:0]  mode_c;
    logic        is_li1;
    logic        is_li2;
    logic        bad_c;
    logic        go_ok;
    logic        go_bad;
    logic [31:0] amax_c;
    logic [31:0] mst_c;
    logic [31:0] amt_c  [AXES];
    logic [3:0]  circ_m;
    logic [3:0]  circ_ctl;
    logic [3:0]  cspsel_c;
    logic [31:0] base_c;
    logic [3:0]  pls;
    logic [2:0]  nstr;
    logic [7:0]  q;
    logic [39:0] prod;
    logic [31:0] str_per;
    logic        step_go;
    logic        last_step;

    assign req    = I_WB_CYC & I_WB_STB & ~ack_r;
    assign wr     = req & I_WB_WE;
    assign ax_a   = I_WB_ADR[ADR_AXL +: 2];
    assign rg_a   = I_WB_ADR[ADR_RGL +: 3];
    assign cmd_wr = wr & (I_WB_ADR == ADDR_CMD) & I_WB_SEL[0];
    assign sel_c  = I_WB_DAT[3:0];
    assign op_c   = I_WB_DAT[CMD_OPL +: 2];
    assign go     = cmd_wr & (op_c == CMD_GO_INIT || op_c == CMD_GO_HIGH);
    assign stop   = cmd_wr & (op_c == CMD_STOP) & |(sel_c & grp_r);

    // start decode: the whole group is named in one write
    assign ctl_c  = first_axis(sel_c);
    assign mode_c = mode_r[ctl_c][6:0];
    assign is_li1 = mode_c == OP_CLIN1 || mode_c == OP_LIN1;
    assign is_li2 = mode_c == OP_CLIN2 || mode_c == OP_LIN2;
    assign bad_c  = (sel_c == 4'h0) || !(is_li1 || is_li2)
                  || (is_li1 && pop4(sel_c) < 3'h2)
                  || (is_li2 && aux_r[ctl_c] == 32'h0);
    assign go_ok  = go & (state_r == S_IDLE) & ~bad_c;
    assign go_bad = go & (state_r == S_IDLE) & bad_c;
    assign base_c = (op_c == CMD_GO_HIGH) ? high_r[ctl_c]
                                          : init_r[ctl_c];

    always_comb begin
        amax_c   = 32'h0;
        cspsel_c = 4'h0;
        for (int a = 0; a < AXES; a++) begin
            if (sel_c[a] && mag(tgt_r[a]) > amax_c) begin
                amax_c = mag(tgt_r[a]);
            end
            cspsel_c[a] = sel_c[a] & mode_r[a][CSP_BIT];
        end
        if (is_li2) begin
            mst_c = aux_r[ctl_c];
        end else if (amax_c == 32'h0) begin
            mst_c = 32'h1;
        end else begin
            mst_c = amax_c;
        end
        for (int a = 0; a < AXES; a++) begin
            amt_c[a] = (!is_li2 && amax_c == 32'h0) ? 32'h1
                                                   : mag(tgt_r[a]);
        end
    end

    // circular group gets its own control axis beside linear 1
    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            circ_m[a] = mode_r[a][6:0] == OP_CW
                     || mode_r[a][6:0] == OP_CCW;
        end
        circ_ctl = |circ_m ? 4'(4'h1 << first_axis(circ_m)) : 4'h0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < AXES; gi++) begin : g_axis
            mali_step_if stp ();
            assign stp.load   = go_ok;
            assign stp.step   = step_go & grp_r[gi];
            assign stp.master = mst_c;
            assign stp.amt    = amt_c[gi];
            assign pls[gi]    = stp.pulse;
            mali_axis u_axis (
                .i_clk  (I_REF_CLK),
                .i_srst (I_SRST),
                .sif    (stp.axis)
            );
        end
    endgenerate

    // only enabled axes that pulsed together count
    assign nstr = pop4(pls & csp_r);
    always_comb begin
        q = Q_UNITY;
        if (!li2_r) begin
            if (nstr >= 3'h3) begin
                q = Q_SQRT3;
            end else if (nstr == 3'h2) begin
                q = Q_SQRT2;
            end
        end
        prod    = 40'(base_r) * 40'(q);
        str_per = prod[Q_FRAC +: 32];
    end

    assign step_go   = (state_r == S_RUN) & ~wait_r & (cnt_r == 32'h0);
    assign last_step = ~cont_r & (32'(steps_r + 32'h1) >= master_r);

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            for (int a = 0; a < AXES; a++) begin
                mode_r[a] <= MODE_RST;
                tgt_r[a]  <= AMT_RST;
                aux_r[a]  <= AMT_RST;
                high_r[a] <= SPEED_RST;
                init_r[a] <= SPEED_RST;
            end
        end else if (wr && !I_WB_ADR[ADR_GLB]) begin
            unique case (rg_a)
                RG_MODE: mode_r[ax_a] <= merge(mode_r[ax_a], I_WB_DAT, I_WB_SEL);
                RG_TGT:  tgt_r[ax_a]  <= merge(tgt_r[ax_a], I_WB_DAT, I_WB_SEL);
                RG_AUX:  aux_r[ax_a]  <= merge(aux_r[ax_a], I_WB_DAT, I_WB_SEL);
                RG_HIGH: high_r[ax_a] <= merge(high_r[ax_a], I_WB_DAT, I_WB_SEL);
                RG_INIT: init_r[ax_a] <= merge(init_r[ax_a], I_WB_DAT, I_WB_SEL);
                default: ;
            endcase
        end
    end

    // every access answered one cycle later; holes read zero
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r  <= req;
            rdat_r <= 32'h0;
            if (req && !I_WB_WE && !I_WB_ADR[ADR_GLB]) begin
                unique case (rg_a)
                    RG_MODE: rdat_r <= mode_r[ax_a];
                    RG_TGT:  rdat_r <= tgt_r[ax_a];
                    RG_AUX:  rdat_r <= aux_r[ax_a];
                    RG_HIGH: rdat_r <= high_r[ax_a];
                    RG_INIT: rdat_r <= init_r[ax_a];
                    RG_STAT: begin
                        rdat_r[SB_RUN] <= run_r & grp_r[ax_a];
                        rdat_r[SB_END] <= end_r & grp_r[ax_a];
                        rdat_r[SB_ERR] <= err_r & grp_r[ax_a];
                        rdat_r[SB_CTL] <= ctlm_r[ax_a] | circ_ctl[ax_a];
                    end
                    RG_SPEED: begin
                        if (ctlm_r[ax_a] && run_r) begin
                            rdat_r <= per_r;
                        end else if (circ_ctl[ax_a]) begin
                            rdat_r <= high_r[ax_a];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            state_r  <= S_IDLE;
            grp_r    <= 4'h0;
            csp_r    <= 4'h0;
            ctlm_r   <= 4'h0;
            dir_r    <= 4'h0;
            li2_r    <= 1'b0;
            cont_r   <= 1'b0;
            run_r    <= 1'b0;
            end_r    <= 1'b0;
            err_r    <= 1'b0;
            wait_r   <= 1'b0;
            master_r <= AMT_RST;
            steps_r  <= AMT_RST;
            base_r   <= MIN_PER;
            per_r    <= MIN_PER;
            cnt_r    <= AMT_RST;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    wait_r <= 1'b0;
                    if (go_ok) begin
                        state_r  <= S_RUN;
                        grp_r    <= sel_c;
                        csp_r    <= is_li2 ? 4'h0 : cspsel_c;
                        ctlm_r   <= is_li2 ? sel_c
                                           : 4'(4'h1 << ctl_c);
                        li2_r    <= is_li2;
                        cont_r   <= mode_c == OP_CLIN1
                                 || mode_c == OP_CLIN2;
                        run_r    <= 1'b1;
                        end_r    <= 1'b0;
                        err_r    <= 1'b0;
                        master_r <= mst_c;
                        steps_r  <= AMT_RST;
                        base_r   <= base_c < MIN_PER ? MIN_PER : base_c;
                        per_r    <= base_c < MIN_PER ? MIN_PER : base_c;
                        cnt_r    <= AMT_RST;
                        for (int a = 0; a < AXES; a++) begin
                            dir_r[a] <= sel_c[a] & tgt_r[a][31];
                        end
                    end else if (go_bad) begin
                        grp_r  <= sel_c;
                        ctlm_r <= 4'h0;
                        run_r  <= 1'b0;
                        end_r  <= 1'b1;
                        err_r  <= 1'b1;
                    end
                end
                S_RUN: begin
                    if (stop) begin
                        state_r <= S_IDLE;
                        run_r   <= 1'b0;
                        end_r   <= 1'b1;
                    end else if (step_go) begin
                        wait_r  <= 1'b1;
                        steps_r <= 32'(steps_r + 32'h1);
                        if (last_step) begin
                            state_r <= S_IDLE;
                            run_r   <= 1'b0;
                            end_r   <= 1'b1;
                        end
                    end else if (wait_r) begin
                        // pulses of the last step are now visible
                        wait_r <= 1'b0;
                        per_r  <= str_per;
                        cnt_r  <= 32'(str_per - MIN_PER);
                    end else begin
                        cnt_r <= 32'(cnt_r - 32'h1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            pls_r <= 4'h0;
        end else begin
            pls_r <= pls;
        end
    end

    assign O_WB_ACK = ack_r;
    assign O_WB_DAT = rdat_r;
    assign O_PULSE  = pls_r;
    assign O_DIR    = dir_r;

    ack_single_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_WB_ACK |=> !O_WB_ACK)
        else $error("ack held two cycles");
    ack_answer_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        req |=> O_WB_ACK)
        else $error("request not answered next cycle");
    single_axis_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        go && state_r == S_IDLE && is_li1 && pop4(sel_c) == 3'h1
        |=> err_r && !run_r && state_r == S_IDLE)
        else $error("single axis linear start not refused");
    aux_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        go && state_r == S_IDLE && is_li2 && aux_r[ctl_c] == 32'h0
        |=> err_r && end_r)
        else $error("zero aux start not refused");
    li2_flat_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        state_r == S_RUN && li2_r && wait_r && !stop |=> per_r == base_r)
        else $error("interval stretched in linear 2");
    two_axis_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        state_r == S_RUN && !li2_r && wait_r && !stop
        && pop4(pls & csp_r) == 3'h2
        |=> per_r == 32'((40'($past(base_r)) * 40'hB5) >> 7))
        else $error("two axis interval not sqrt2");
    end_group_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        step_go && last_step && !stop
        |=> !run_r && end_r && state_r == S_IDLE)
        else $error("group did not end at master count");
    cont_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        state_r == S_RUN && cont_r && !stop |=> state_r == S_RUN && run_r)
        else $error("continuous mode stopped without command");
endmodule // mali_interp

//--- bench/mali_drv_model.sv
`timescale 1ns/100ps
module mali_drv_model
    import mali_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic [3:0]  i_pulse,
    input  wire logic [3:0]  i_dir,
    output logic      [31:0] o_pos [AXES],
    output logic      [31:0] o_gap [AXES]
);
    logic [31:0] cyc_r;
    logic [31:0] last_r [AXES];

    always_ff @(posedge i_clk) begin
        cyc_r <= i_srst ? 32'h0 : cyc_r + 32'h1;
    end

    // a driver steps one unit per pulse, sense from the direction level
    always_ff @(posedge i_clk) begin
        for (int a = 0; a < AXES; a++) begin
            if (i_srst) begin
                o_pos[a]  <= 32'h0;
                o_gap[a]  <= 32'h0;
                last_r[a] <= 32'h0;
            end else if (i_pulse[a]) begin
                o_pos[a]  <= i_dir[a] ? o_pos[a] - 32'h1 : o_pos[a] + 32'h1;
                o_gap[a]  <= cyc_r - last_r[a];
                last_r[a] <= cyc_r;
            end
        end
    end
endmodule // mali_drv_model

//--- bench/mali_interp_bench.sv
`timescale 1ns/100ps
module mali_interp_bench
    import mali_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [3:0]  pulse;
    logic [3:0]  dir;
    logic [31:0] pos [AXES];
    logic [31:0] gap [AXES];
    logic [31:0] p0 [AXES];
    int          num_errors = 0;
    int          num_checks = 0;

    always #2 clk = ~clk;

    mali_interp mali_interp_inst (
        .I_REF_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(4'hF),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_PULSE(pulse), .O_DIR(dir)
    );

    mali_drv_model mali_drv_model_inst (
        .i_clk(clk), .i_srst(srst), .i_pulse(pulse), .i_dir(dir),
        .o_pos(pos), .o_gap(gap)
    );

    function automatic logic [7:0] ad(input int a, input logic [2:0] r);
        return {1'b0, 2'(a), r, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got,
                     exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) begin
            chk(32'(ack), 32'h1, "bus ack");
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask

    task automatic setup(input int a, input logic [31:0] md, tg, hs);
        wr(ad(a, RG_MODE), md);
        wr(ad(a, RG_TGT), tg);
        wr(ad(a, RG_HIGH), hs);
    endtask

    task automatic cmd(input logic [3:0] s, input logic [1:0] go);
        wr(ADDR_CMD, (32'(go) << CMD_OPL) | 32'(s));
    endtask

    task automatic wait_end(input int a);
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            rd(ad(a, RG_STAT), s);
            n++;
        end while (s[SB_END] !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            chk(32'(s[SB_END]), 32'h1, "end timeout");
        end
        // last pulse reaches the driver model two cycles after the end flag
        repeat (4) @(posedge clk);
    endtask

    task automatic t_reset_map;
        logic [31:0] q;
        rd(ad(0, RG_MODE), q);
        chk(q, MODE_RST, "mode reset");
        rd(ad(2, RG_HIGH), q);
        chk(q, SPEED_RST, "speed reset");
        wr(ad(1, 3'h7), 32'h1234_5678);
        rd(ad(1, 3'h7), q);
        chk(q, 32'h0, "unmapped");
        $display("test reset_map done");
    endtask

    // master Y negative, slaves X and Z, X is the control axis
    task automatic t_lin1;
        logic [31:0] s [3];
        p0 = pos;
        setup(0, 32'(OP_LIN1), 32'd5, 32'd4);
        setup(1, 32'(OP_LIN1), 32'hFFFF_FFF6, 32'd4);
        setup(2, 32'(OP_LIN1), 32'd2, 32'd4);
        cmd(4'h7, CMD_GO_HIGH);
        chk(32'(dir), 32'h2, "direction");
        wait_end(0);
        chk(pos[0] - p0[0], 32'd5, "x count");
        chk(pos[1] - p0[1], 32'hFFFF_FFF6, "y count");
        chk(pos[2] - p0[2], 32'd2, "z count");
        chk(gap[1], 32'd4, "master every step");
        for (int a = 0; a < 3; a++) begin
            rd(ad(a, RG_STAT), s[a]);
            chk(s[a] & 32'h7, 32'h2, "status end");
        end
        chk(32'(s[0][SB_CTL]), 32'h1, "x control");
        chk(32'(s[1][SB_CTL]), 32'h0, "y not control");
        $display("test lin1 done");
    endtask

    task automatic t_errors;
        logic [31:0] q;
        p0 = pos;
        setup(0, 32'(OP_LIN1), 32'd5, 32'd4);
        cmd(4'h1, CMD_GO_HIGH);
        rd(ad(0, RG_STAT), q);
        chk(q & 32'h7, 32'h6, "single axis lin1");
        setup(0, 32'(OP_LIN2), 32'd5, 32'd4);
        setup(1, 32'(OP_LIN2), 32'd3, 32'd4);
        wr(ad(0, RG_AUX), 32'h0);
        wr(ad(1, RG_AUX), 32'h0);
        cmd(4'h3, CMD_GO_HIGH);
        rd(ad(1, RG_STAT), q);
        chk(q & 32'h7, 32'h6, "zero aux");
        chk(pos[0] - p0[0], 32'h0, "no pulses");
        $display("test errors done");
    endtask

    task automatic t_cont_zero;
        logic [31:0] q;
        p0 = pos;
        setup(0, 32'(OP_CLIN1), 32'h0, 32'd4);
        setup(1, 32'(OP_CLIN1), 32'h0, 32'd4);
        cmd(4'h3, CMD_GO_HIGH);
        repeat (200) @(posedge clk);
        rd(ad(1, RG_STAT), q);
        chk(q & 32'h7, 32'h1, "still running");
        rd(ad(0, RG_SPEED), q);
        chk(q, 32'd4, "control axis speed");
        rd(ad(1, RG_SPEED), q);
        chk(q, 32'h0, "slave speed hidden");
        cmd(4'h3, CMD_STOP);
        repeat (10) @(posedge clk);
        rd(ad(0, RG_STAT), q);
        chk(32'(q[SB_RUN]), 32'h0, "stopped");
        chk(pos[0] - p0[0], pos[1] - p0[1], "equal rates");
        chk(32'(pos[0] - p0[0] > 32'd20), 32'h1, "pulsed");
        $display("test cont_zero done");
    endtask

    // interval after simultaneous pulses, base 8: sqrt2 11, sqrt3 13
    task automatic t_const_speed;
        logic [3:0]  sl [4] = '{4'h3, 4'h3, 4'h7, 4'hF};
        logic [3:0]  en [4] = '{4'h3, 4'h1, 4'h7, 4'hF};
        logic [31:0] ex [4] = '{32'd11, 32'd8, 32'd13, 32'd13};
        for (int k = 0; k < 4; k++) begin
            for (int a = 0; a < AXES; a++) begin
                setup(a, (32'(en[k][a]) << CSP_BIT) | 32'(OP_LIN1), 32'd6,
                      32'd8);
            end
            cmd(sl[k], CMD_GO_HIGH);
            wait_end(0);
            chk(gap[0], ex[k], "stretched gap");
        end
        $display("test const_speed done");
    endtask

    // Z and U in linear 2, stretching bits set, started at initial speed
    task automatic t_lin2;
        logic [31:0] q;
        p0 = pos;
        setup(2, (32'h1 << CSP_BIT) | 32'(OP_LIN2), 32'd4, 32'd9);
        setup(3, (32'h1 << CSP_BIT) | 32'(OP_LIN2), 32'hFFFF_FFFE, 32'd9);
        wr(ad(2, RG_AUX), 32'd4);
        wr(ad(3, RG_AUX), 32'd4);
        wr(ad(2, RG_INIT), 32'd6);
        cmd(4'hC, CMD_GO_INIT);
        chk(32'(dir), 32'h8, "u negative");
        rd(ad(3, RG_SPEED), q);
        chk(q, 32'd6, "master speed");
        rd(ad(3, RG_STAT), q);
        chk(q & 32'hF, 32'h9, "every axis control");
        wait_end(2);
        chk(pos[2] - p0[2], 32'd4, "z count");
        chk(pos[3] - p0[3], 32'hFFFF_FFFE, "u count");
        chk(gap[2], 32'd6, "initial speed unstretched");
        chk(gap[3], 32'd12, "u half rate");
        setup(0, 32'(OP_CW), 32'h0, 32'd7);
        rd(ad(0, RG_STAT), q);
        chk(32'(q[SB_CTL]), 32'h1, "circular control");
        rd(ad(0, RG_SPEED), q);
        chk(q, 32'd7, "circular speed");
        $display("test lin2 done");
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset_map();
        t_lin1();
        t_errors();
        t_cont_zero();
        t_const_speed();
        t_lin2();
        final_report();
    end

    // runs take about a thousand cycles; allow far more
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule // mali_interp_bench
